// ==== tcc_map.svh ====
// Register map, field positions, reset values and clock taps of the timer
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// Channel register offsets inside a 64-byte channel window
`define TCC_CCR_OFS 6'h00
`define TCC_CMR_OFS 6'h04
`define TCC_CV_OFS 6'h10
`define TCC_RA_OFS 6'h14
`define TCC_RB_OFS 6'h18
`define TCC_RC_OFS 6'h1c
`define TCC_SR_OFS 6'h20
// Block registers
`define TCC_BCR_OFS 8'hc0
`define TCC_BMR_OFS 8'hc4
`define TCC_BLK_SEL 2'h3
// Command bits
`define TCC_SYNC_BIT 0
`define TCC_COUNTER_CLOCK_ON_CMD_BIT 0
`define TCC_COUNTER_CLOCK_OFF_CMD_BIT 1
`define TCC_SOFT_TRIGGER_CMD_BIT 2
// Mode register fields
`define TCC_CLKS_LSB 0
`define TCC_COUNT_EDGE_INVERT_BIT 3
`define TCC_BURST_LSB 4
`define TCC_STOP_ON_B_LOAD_BIT 6
`define TCC_DISABLE_ON_B_LOAD_BIT 7
`define TCC_ETRG_LSB 8
`define TCC_TRIGGER_PIN_SELECT_BIT 10
`define TCC_COMPARE_C_TRIGGER_EN_BIT 14
`define TCC_WAVE_BIT 15
`define TCC_A_LOAD_EDGE_LSB 16
`define TCC_B_LOAD_EDGE_LSB 18
`define TCC_CMR_MASK 20'hfc7ff
`define TCC_CMR_RST 20'h00000
`define TCC_BMR_RST 6'h00
// Status bits
`define TCC_ST_COVF 0
`define TCC_ST_LOVR 1
`define TCC_ST_CPC 4
`define TCC_ST_A_LOAD_EDGE 5
`define TCC_ST_B_LOAD_EDGE 6
`define TCC_ST_ETRG 7
`define TCC_ST_CLKSTA 16
// Prescaler taps for master clock /2, /8, /32, /128, /1024
`define TCC_PRESC_W 10
`define TCC_TAP2 0
`define TCC_TAP8 2
`define TCC_TAP32 4
`define TCC_TAP128 6
`define TCC_TAP1024 9
`endif

// ==== tcc_pkg.sv ====
// Types of the timer capture control block
package tcc_pkg;
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] ra;
		logic [15:0] rb;
		logic [15:0] rc;
		logic [19:0] cmr;
		logic en;
		logic run;
		logic clk_q;
		logic pa_q;
		logic pb_q;
		logic a_done;
		logic ra_unread;
		logic rb_unread;
		logic [7:0] status;
	} tcc_chan_t;

	typedef struct packed {
		logic [9:0] presc;
		logic [5:0] bmr;
		tcc_chan_t [2:0] chan;
		logic ack;
		logic [31:0] rdata;
	} tcc_state_t;
endpackage : tcc_pkg

// ==== tcc_capture_ctrl.sv ====
// Three-channel 16-bit timer in capture mode with Wishbone register access
//
// Operation
// - Block sync command bit 0 triggers all three channels at once.
// - Line 0 source: clock pin 0, none, channel 1 pin A, channel 2 pin A.
// - Line 1 source: clock pin 1, none, channel 0 pin A, channel 2 pin A.
// - Line 2 source: clock pin 2, none, channel 0 pin A, channel 1 pin A.
// - Clock-on command enables counting unless clock-off is set too.
// - Clock-off command disables counting and beats a simultaneous on.
// - Software trigger command clears the counter and starts its clock.
// - Clock select picks master clock /2../1024 or internal lines 0..2.
// - Edge invert bit chooses rising or falling edge of selected clock.
// - Burst field ANDs selected clock with line 0, 1 or 2, or not.
// - Stop-on-B-load halts the counter clock when B is captured.
// - Disable-on-B-load disables the counter clock when B is captured.
// - Trigger edge field: none, rising, falling or both edges.
// - Trigger pin select takes pin B when zero, pin A when one.
// - Compare-C trigger enable lets a C match clear and restart.
// - Mode bit 15 selects capture at zero, waveform at one.
// - A-load field in bits 17:16 picks the pin A edge loading A.
// - B-load field in bits 19:18 picks the pin A edge loading B.
// - B loads only after A has loaded since last trigger or B load.
// - Reloading A or B before it was read overwrites and flags overrun.
// - Status bits 0, 1 and 4 to 7 set on events and clear when status is read.
//
// Local design decision: register access over Wishbone.
`include "tcc_map.svh"

module tcc_capture_ctrl
	import tcc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] timer_clock_pin_i,
	input wire logic [2:0] channel_pin_a_i,
	input wire logic [2:0] channel_pin_b_i,
	output logic [2:0] counter_clock_enabled_o
);

	// ***********************************************************
	// Helpers
	// ***********************************************************
	function automatic logic edge_hit(input logic [1:0] code,
		input logic cur, input logic prev);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = ~cur & prev;
		unique case (code)
			2'h1: edge_hit = rise;
			2'h2: edge_hit = fall;
			2'h3: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	function automatic logic line_route(input logic [1:0] code,
		input logic pin, input logic alt_a, input logic alt_b);
		unique case (code)
			2'h0: line_route = pin;
			2'h1: line_route = 1'b0;
			2'h2: line_route = alt_a;
			default: line_route = alt_b;
		endcase
	endfunction : line_route

	function automatic logic clock_tap(input logic [2:0] code,
		input logic [9:0] presc, input logic [2:0] lines);
		unique case (code)
			3'h0: clock_tap = presc[`TCC_TAP2];
			3'h1: clock_tap = presc[`TCC_TAP8];
			3'h2: clock_tap = presc[`TCC_TAP32];
			3'h3: clock_tap = presc[`TCC_TAP128];
			3'h4: clock_tap = presc[`TCC_TAP1024];
			3'h5: clock_tap = lines[0];
			3'h6: clock_tap = lines[1];
			default: clock_tap = lines[2];
		endcase
	endfunction : clock_tap

	function automatic logic burst_gate(input logic [1:0] code,
		input logic [2:0] lines);
		unique case (code)
			2'h0: burst_gate = 1'b1;
			2'h1: burst_gate = lines[0];
			2'h2: burst_gate = lines[1];
			default: burst_gate = lines[2];
		endcase
	endfunction : burst_gate

	tcc_state_t r;
	tcc_state_t next_r;

	// ***********************************************************
	// Bus decode
	// ***********************************************************
	logic acc;
	logic wr_now;
	logic rd_now;
	logic [1:0] ch;
	logic [5:0] ofs;
	logic [31:0] bmask;
	logic [31:0] wm;
	logic sync_wr;
	logic [2:0] xc;

	assign acc = wb_cyc_i & wb_stb_i;
	// Writes and read side effects land on the edge where ack is seen
	assign wr_now = acc & wb_we_i & r.ack;
	assign rd_now = acc & ~wb_we_i & r.ack;
	assign ch = wb_adr_i[7:6];
	assign ofs = wb_adr_i[5:0];
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wm = wb_dat_i & bmask;
	assign sync_wr = wr_now && wb_adr_i == `TCC_BCR_OFS &&
		wm[`TCC_SYNC_BIT];

	assign xc[0] = line_route(r.bmr[1:0], timer_clock_pin_i[0],
		channel_pin_a_i[1], channel_pin_a_i[2]);
	assign xc[1] = line_route(r.bmr[3:2], timer_clock_pin_i[1],
		channel_pin_a_i[0], channel_pin_a_i[2]);
	assign xc[2] = line_route(r.bmr[5:4], timer_clock_pin_i[2],
		channel_pin_a_i[0], channel_pin_a_i[1]);

	// ***********************************************************
	// Per-channel events
	// ***********************************************************
	logic [2:0] cmd_wr;
	logic [2:0] gated;
	logic [2:0] tick;
	logic [2:0] match;
	logic [2:0] ext_hit;
	logic [2:0] trig;
	logic [2:0] ra_hit;
	logic [2:0] rb_hit;

	for (genvar g = 0; g < 3; g++) begin : g_ch
		logic [19:0] m;
		logic capt;
		logic tpin;
		logic tprev;
		assign m = r.chan[g].cmr;
		// Waveform mode is not built here, so capture logic idles in it
		assign capt = ~m[`TCC_WAVE_BIT];
		assign cmd_wr[g] = wr_now && ch == 2'(g) && ofs == `TCC_CCR_OFS;
		assign gated[g] = clock_tap(m[2:0], r.presc, xc) &
			burst_gate(m[5:4], xc);
		// Live clock is compared with its copy from the last edge, so an edge counts on the next clock
		assign tick[g] = r.chan[g].en & r.chan[g].run &
			(m[`TCC_COUNT_EDGE_INVERT_BIT] ? (r.chan[g].clk_q & ~gated[g]) :
			(~r.chan[g].clk_q & gated[g]));
		assign match[g] = tick[g] && r.chan[g].cnt == r.chan[g].rc;
		assign tpin = m[`TCC_TRIGGER_PIN_SELECT_BIT] ? channel_pin_a_i[g] :
			channel_pin_b_i[g];
		assign tprev = m[`TCC_TRIGGER_PIN_SELECT_BIT] ? r.chan[g].pa_q :
			r.chan[g].pb_q;
		assign ext_hit[g] = capt &
			edge_hit(m[9:8], tpin, tprev);
		assign trig[g] = sync_wr | (cmd_wr[g] & wm[`TCC_SOFT_TRIGGER_CMD_BIT]) |
			(match[g] & m[`TCC_COMPARE_C_TRIGGER_EN_BIT]) | ext_hit[g];
		assign ra_hit[g] = capt & edge_hit(m[17:16], channel_pin_a_i[g],
			r.chan[g].pa_q);
		assign rb_hit[g] = capt & r.chan[g].a_done &
			edge_hit(m[19:18], channel_pin_a_i[g],
			r.chan[g].pa_q);
	end

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb begin
		logic [7:0] set;
		logic [31:0] rd;
		set = 8'h00;
		rd = 32'h0000_0000;
		next_r = r;
		next_r.presc = r.presc + 10'h001;
		next_r.ack = acc & ~r.ack;
		if (wr_now && wb_adr_i == `TCC_BMR_OFS) begin
			next_r.bmr = (r.bmr & ~bmask[5:0]) | wm[5:0];
		end
		for (int i = 0; i < 3; i++) begin
			set = 8'h00;
			next_r.chan[i].clk_q = gated[i];
			next_r.chan[i].pa_q = channel_pin_a_i[i];
			next_r.chan[i].pb_q = channel_pin_b_i[i];
			if (trig[i]) begin
				next_r.chan[i].cnt = 16'h0000;
				next_r.chan[i].run = 1'b1;
				next_r.chan[i].a_done = 1'b0;
			end else if (tick[i]) begin
				next_r.chan[i].cnt = r.chan[i].cnt + 16'h0001;
				set[`TCC_ST_COVF] = r.chan[i].cnt == 16'hffff;
			end
			set[`TCC_ST_CPC] = match[i];
			set[`TCC_ST_ETRG] = ext_hit[i];
			if (ra_hit[i]) begin
				next_r.chan[i].ra = r.chan[i].cnt;
				next_r.chan[i].a_done = 1'b1;
				set[`TCC_ST_A_LOAD_EDGE] = 1'b1;
				set[`TCC_ST_LOVR] = r.chan[i].ra_unread;
			end
			if (rb_hit[i]) begin
				next_r.chan[i].rb = r.chan[i].cnt;
				next_r.chan[i].a_done = 1'b0;
				set[`TCC_ST_B_LOAD_EDGE] = 1'b1;
				if (r.chan[i].rb_unread) begin
					set[`TCC_ST_LOVR] = 1'b1;
				end
				if (r.chan[i].cmr[`TCC_STOP_ON_B_LOAD_BIT] && !trig[i]) begin
					next_r.chan[i].run = 1'b0;
				end
				if (r.chan[i].cmr[`TCC_DISABLE_ON_B_LOAD_BIT]) begin
					next_r.chan[i].en = 1'b0;
				end
			end
			// Software commands come last so they override load effects
			if (cmd_wr[i] && wm[`TCC_COUNTER_CLOCK_OFF_CMD_BIT]) begin
				next_r.chan[i].en = 1'b0;
			end else if (cmd_wr[i] && wm[`TCC_COUNTER_CLOCK_ON_CMD_BIT]) begin
				next_r.chan[i].en = 1'b1;
			end
			if (wr_now && ch == 2'(i)) begin
				if (ofs == `TCC_CMR_OFS) begin
					next_r.chan[i].cmr = ((r.chan[i].cmr & ~bmask[19:0]) |
						wm[19:0]) & `TCC_CMR_MASK;
				end
				if (ofs == `TCC_RC_OFS) begin
					next_r.chan[i].rc = (r.chan[i].rc & ~bmask[15:0]) |
						wm[15:0];
				end
			end
			// Reads clear with what was returned, so a new event survives
			if (rd_now && ch == 2'(i) && ofs == `TCC_SR_OFS) begin
				next_r.chan[i].status = r.chan[i].status &
					~r.rdata[7:0];
			end
			if (rd_now && ch == 2'(i) && ofs == `TCC_RA_OFS) begin
				next_r.chan[i].ra_unread = 1'b0;
			end
			if (rd_now && ch == 2'(i) && ofs == `TCC_RB_OFS) begin
				next_r.chan[i].rb_unread = 1'b0;
			end
			if (ra_hit[i]) begin
				next_r.chan[i].ra_unread = 1'b1;
			end
			if (rb_hit[i]) begin
				next_r.chan[i].rb_unread = 1'b1;
			end
			next_r.chan[i].status = next_r.chan[i].status | set;
		end
		if (ch == `TCC_BLK_SEL) begin
			if (wb_adr_i == `TCC_BMR_OFS) begin
				rd = {26'h0, r.bmr};
			end
		end else begin
			unique case (ofs)
				`TCC_CMR_OFS: rd = {12'h000, r.chan[ch].cmr};
				`TCC_CV_OFS: rd = {16'h0000, r.chan[ch].cnt};
				`TCC_RA_OFS: rd = {16'h0000, r.chan[ch].ra};
				`TCC_RB_OFS: rd = {16'h0000, r.chan[ch].rb};
				`TCC_RC_OFS: rd = {16'h0000, r.chan[ch].rc};
				`TCC_SR_OFS: begin
					rd = {24'h000000, r.chan[ch].status};
					rd[`TCC_ST_CLKSTA] = r.chan[ch].en;
				end
				default: rd = 32'h0000_0000;
			endcase
		end
		if (acc && !r.ack) begin
			next_r.rdata = rd;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			for (int i = 0; i < 3; i++) begin
				r.chan[i].cmr <= `TCC_CMR_RST;
			end
			r.bmr <= `TCC_BMR_RST;
		end else begin
			r <= next_r;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.rdata;
	for (genvar g = 0; g < 3; g++) begin : g_out
		assign counter_clock_enabled_o[g] = r.chan[g].en;
	end

	// ***********************************************************
	// Assertions
	// ***********************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_sync_all;
		sync_wr |=> r.chan[0].cnt == 16'h0 && r.chan[1].cnt == 16'h0 &&
			r.chan[2].cnt == 16'h0 && (&r.chan[0].run);
	endproperty
	a_sync_all: assert property (p_sync_all)
		else $error("sync did not trigger all channels");

	property p_route0;
		r.bmr[1:0] == 2'h2 |-> xc[0] == channel_pin_a_i[1];
	endproperty
	a_route0: assert property (p_route0)
		else $error("line 0 routing wrong");

	property p_route2;
		r.bmr[5:4] == 2'h1 |-> !xc[2];
	endproperty
	a_route2: assert property (p_route2)
		else $error("line 2 not idle");

	property p_clk_on;
		cmd_wr[0] && wm[`TCC_COUNTER_CLOCK_ON_CMD_BIT] && !wm[`TCC_COUNTER_CLOCK_OFF_CMD_BIT] |=>
			counter_clock_enabled_o[0];
	endproperty
	a_clk_on: assert property (p_clk_on)
		else $error("clock on command ignored");

	property p_clk_off;
		cmd_wr[0] && wm[`TCC_COUNTER_CLOCK_OFF_CMD_BIT] |=> !counter_clock_enabled_o[0]
			##1 !counter_clock_enabled_o[0] || $past(cmd_wr[0]);
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("clock off did not win");

	sequence s_rb_stop;
		rb_hit[0] && r.chan[0].cmr[`TCC_STOP_ON_B_LOAD_BIT] && !trig[0];
	endsequence
	property p_rb_stop;
		s_rb_stop |=> !r.chan[0].run ##1 !tick[0];
	endproperty
	a_rb_stop: assert property (p_rb_stop)
		else $error("B load did not stop clock");

	// A further B load must wait for a fresh A load
	property p_rb_order;
		rb_hit[0] |-> r.chan[0].a_done ##1 !r.chan[0].a_done;
	endproperty
	a_rb_order: assert property (p_rb_order)
		else $error("B loaded without prior A");

	sequence s_a_again;
		ra_hit[0] && r.chan[0].ra_unread;
	endsequence
	property p_overrun;
		s_a_again |=> r.chan[0].status[`TCC_ST_LOVR];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");

	property p_capture;
		ra_hit[0] |=> r.chan[0].ra == $past(r.chan[0].cnt) &&
			r.chan[0].status[`TCC_ST_A_LOAD_EDGE];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value wrong");

	property p_no_count;
		!r.chan[0].en |=> r.chan[0].cnt == $past(r.chan[0].cnt) ||
			$past(trig[0]);
	endproperty
	a_no_count: assert property (p_no_count)
		else $error("disabled counter moved");

endmodule : tcc_capture_ctrl

// ==== tcc_capture_ctrl_tb.sv ====
// Self-checking bench for the timer capture control block
module tcc_capture_ctrl_tb
	import tcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	`define TCC_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
		fail_count++; $display("MISMATCH %s expected %h seen %h", nm, e, g); \
		end end
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [2:0] tclk = 3'h0;
	logic [2:0] pa = 3'h0;
	logic [2:0] pb = 3'h0;
	logic [2:0] en;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] q;
	logic [7:0] b;
	tcc_capture_ctrl tcc_capture_ctrl_i (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.timer_clock_pin_i(tclk), .channel_pin_a_i(pa),
		.channel_pin_b_i(pb), .counter_clock_enabled_o(en));
	always #12.5 clk = ~clk;
	// ********************
	// Bus and pin tasks
	// ********************
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, 4'hf, d, r);
	endtask : wr
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		logic [31:0] r;
		wb(1'b0, a, 4'hf, 32'h0, r);
		`TCC_CHK(nm, e, r & m)
	endtask : chk_rd
	// Pins held four cycles so the edge detect and counter settle
	task automatic pin(input int g, input int i, input logic v);
		@(posedge clk);
		case (g)
			0: tclk[i] <= v;
			1: pa[i] <= v;
			default: pb[i] <= v;
		endcase
		repeat (4) @(posedge clk);
	endtask : pin
	task automatic pls(input int g, input int i, input int n);
		repeat (n) begin
			pin(g, i, 1'b1);
			pin(g, i, 1'b0);
		end
	endtask : pls
	task automatic en_chk(input logic [31:0] cmd, input logic e);
		wr(8'h00, cmd);
		repeat (2) @(posedge clk);
		`TCC_CHK("enable", e, en[0])
	endtask : en_chk
	task automatic ext_case(input int abe, input int e);
		logic [15:0] c;
		wr(8'h04, 32'(5 | (e << 8) | (abe << 10)));
		wr(8'h00, 32'h5);
		pls(0, 0, 2);
		pin(abe ? 1 : 2, 0, 1'b1);
		c = (e == 1 || e == 3) ? 16'd0 : 16'd2;
		chk_rd(8'h10, 32'hffff, {16'h0, c}, "count rise");
		pls(0, 0, 1);
		pin(abe ? 1 : 2, 0, 1'b0);
		c = (e >= 2) ? 16'd0 : c + 16'd1;
		chk_rd(8'h10, 32'hffff, {16'h0, c}, "count fall");
	endtask : ext_case
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// ********************
	// Tests
	// ********************
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk_rd(8'h04, 32'hffffffff, 32'h0, "mode reset");
		chk_rd(8'hc4, 32'hffffffff, 32'h0, "routing reset");
		chk_rd(8'h00, 32'hffffffff, 32'h0, "command read");
		chk_rd(8'h08, 32'hffffffff, 32'h0, "unmapped read");
		`TCC_CHK("enable reset", 3'h0, en)
		wr(8'h04, 32'hffffffff);
		chk_rd(8'h04, 32'hffffffff, 32'hfc7ff, "mode mask");
		wb(1'b1, 8'hc4, 4'h0, 32'h3f, q);
		chk_rd(8'hc4, 32'hffffffff, 32'h0, "no lane write");
		wr(8'h04, 32'h0);
		$display("test registers done");
		en_chk(32'h1, 1'b1);
		en_chk(32'h0, 1'b1);
		en_chk(32'h3, 1'b0);
		en_chk(32'h1, 1'b1);
		en_chk(32'h2, 1'b0);
		$display("test enable done");
		// Count each line through every routing code, incl. the dead one
		for (int k = 0; k < 3; k++) begin
			for (int c = 0; c < 4; c++) begin
				b = 8'(k * 64);
				wr(8'hc4, 32'(c << (2 * k)));
				wr(b + 8'h04, 32'(5 + k));
				wr(b, 32'h5);
				if (c < 2) pls(0, k, 3);
				else if (c == 2) pls(1, (k == 0) ? 1 : 0, 3);
				else pls(1, (k == 2) ? 1 : 2, 3);
				chk_rd(b + 8'h10, 32'hffff, (c == 1) ? 32'h0 : 32'h3,
					"line count");
			end
		end
		wr(8'hc4, 32'h0);
		$display("test routing done");
		for (int v = 0; v < 2; v++) begin
			wr(8'h04, 32'(5 | (v << 3)));
			wr(8'h00, 32'h5);
			pin(0, 0, 1'b1);
			chk_rd(8'h10, 32'hffff, 32'(1 - v), "edge rise");
			pin(0, 0, 1'b0);
			chk_rd(8'h10, 32'hffff, 32'h1, "edge fall");
		end
		wr(8'h04, 32'h25);
		wr(8'h00, 32'h5);
		pls(0, 0, 3);
		chk_rd(8'h10, 32'hffff, 32'h0, "gated count");
		pin(0, 1, 1'b1);
		pls(0, 0, 3);
		pin(0, 1, 1'b0);
		chk_rd(8'h10, 32'hffff, 32'h3, "burst count");
		$display("test clocking done");
		for (int i = 0; i < 3; i++) begin
			wr(8'(i * 64 + 4), 32'h5);
			wr(8'(i * 64), 32'h5);
		end
		pls(0, 0, 2);
		wr(8'hc0, 32'h0);
		for (int i = 0; i < 3; i++)
			chk_rd(8'(i * 64 + 16), 32'hffff, 32'h2, "sync zero");
		wr(8'hc0, 32'h1);
		for (int i = 0; i < 3; i++)
			chk_rd(8'(i * 64 + 16), 32'hffff, 32'h0, "sync one");
		$display("test sync done");
		wr(8'h04, 32'h90045);
		wr(8'h00, 32'h5);
		pls(0, 0, 2);
		pin(1, 0, 1'b1);
		pls(0, 0, 1);
		pin(1, 0, 1'b0);
		pls(0, 0, 2);
		chk_rd(8'h10, 32'hffff, 32'h3, "stopped count");
		chk_rd(8'h14, 32'hffff, 32'h2, "reg a");
		chk_rd(8'h18, 32'hffff, 32'h3, "reg b");
		chk_rd(8'h20, 32'h60, 32'h60, "load status");
		chk_rd(8'h20, 32'h60, 32'h0, "status cleared");
		`TCC_CHK("stop keeps enable", 1'b1, en[0])
		wr(8'h04, 32'h90085);
		wr(8'h00, 32'h5);
		pls(1, 0, 1);
		repeat (2) @(posedge clk);
		`TCC_CHK("b load disable", 1'b0, en[0])
		pls(0, 0, 2);
		chk_rd(8'h10, 32'hffff, 32'h0, "disabled count");
		wr(8'h04, 32'h30005);
		wr(8'h00, 32'h5);
		pls(1, 0, 1);
		chk_rd(8'h20, 32'h22, 32'h22, "overrun");
		wr(8'h04, 32'h40005);
		wr(8'h00, 32'h5);
		pls(1, 0, 1);
		chk_rd(8'h20, 32'h40, 32'h0, "b without a");
		$display("test capture done");
		for (int e = 0; e < 4; e++) ext_case(0, e);
		chk_rd(8'h20, 32'h80, 32'h80, "trigger status");
		ext_case(1, 1);
		ext_case(1, 2);
		$display("test trigger done");
		wr(8'h1c, 32'h3);
		for (int t = 0; t < 2; t++) begin
			wr(8'h04, t ? 32'h5 : 32'h4005);
			wr(8'h00, 32'h5);
			pls(0, 0, 5);
			chk_rd(8'h10, 32'hffff, t ? 32'h5 : 32'h1, "c match");
		end
		wr(8'h04, 32'h18005);
		chk_rd(8'h20, 32'h0, 32'h0, "status flush");
		wr(8'h00, 32'h5);
		pls(1, 0, 1);
		chk_rd(8'h20, 32'h20, 32'h0, "wave no capture");
		$display("test compare and mode done");
		tally_and_finish();
	end
endmodule : tcc_capture_ctrl_tb
